/* File: asr_consts.svh */
// Register offsets, field positions, reset values and timing counts for the serial block
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// Register offsets
`define ASR_A_RATE 2'h0
`define ASR_A_CTRL 2'h1
`define ASR_A_STAT 2'h2
`define ASR_A_DATA 2'h3

// Rate register fields
`define ASR_F_RSEL 2:0
`define ASR_F_PSEL 5:4

// Control register fields
`define ASR_B_TXON 3
`define ASR_B_IDIE 4
`define ASR_B_RFIE 5
`define ASR_B_TX_DONE_IRQ_ON 6
`define ASR_B_TEIE 7

// Status register fields
`define ASR_B_FE 1
`define ASR_B_NF 2
`define ASR_B_OVR 3
`define ASR_B_IDLE 4
`define ASR_B_RXF 5
`define ASR_B_TC 6
`define ASR_B_TX_BUFFER_EMPTY_FLAG 7
`define ASR_TX_FLAGS 8'hC0

// Reset values
`define ASR_RST_PSEL 2'h0
`define ASR_RST_CTRL 8'h00
`define ASR_RST_STAT 8'h00

// Timing counts in sample-clock ticks and bits
`define ASR_RT_LAST 4'hF
`define ASR_RT_S0 4'h7
`define ASR_RT_S1 4'h8
`define ASR_RT_S2 4'h9
`define ASR_BIT_LAST 4'hF
`define ASR_STOP_BIT 4'h9
`define ASR_IDLE_RT 8'hA0

`endif

/* File: asr_pkg.sv */
// Types shared by the serial rate and flag block
package asr_pkg;
	typedef enum logic [1:0] {ASR_TX_IDLE, ASR_TX_SHIFT} asr_tx_state_t;
	typedef enum logic [1:0] {ASR_RX_IDLE, ASR_RX_BITS} asr_rx_state_t;
	typedef logic [7:0] asr_byte_t;
	typedef logic [1:0] asr_addr_t;
endpackage

/* File: asr_serial.sv */
// Asynchronous serial port with rate chain, transmitter, receiver and status flags
//
// Overview of operation
// - Rate select divides prescaler output by 1 to 128, giving 16x sample clock.
// - Bit clock is the 16x sample clock divided by sixteen.
// - Rate select keeps its value over reset and is writable any time.
// - Switching the transmitter on sets buffer-empty and done flags.
// - Buffer-empty flag with its mask set requests an interrupt.
// - Done flag with its mask set requests an interrupt.
// - Hardware sets each flag; only the software clearing sequence clears it.
// - Switching transmitter off lets the character in flight finish.
// - Only device reset stops the transmitter at once.
// - Disabled while idle, the pin returns to general I/O on a bit tick.
// - Disabled mid-character, queued characters are dropped; pin released afterwards.
// - Done and buffer-empty set when that last character ends.
// - Receiver keeps five flags; full, overrun and idle may interrupt.
// - Full flag set when a character lands in the holding buffer.
// - On overrun the new character is dropped, buffer kept.
// - Overrun sets the overrun flag instead of the full flag.
// - Noise and framing describe the held character and never interrupt.
// - Line is idle after one whole character time at one.
// - Idle flag set only on busy-to-idle change, not repeatedly.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "asr_consts.svh"

module asr_serial (
	input wire logic core_clk,
	input wire logic resetn,
	input wire asr_pkg::asr_addr_t reg_addr,
	input wire asr_pkg::asr_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output asr_pkg::asr_byte_t reg_rdata,
	input wire logic rx_pin,
	output logic tx_pin_out,
	output logic tx_pin_oe,
	output logic irq_req
);
	import asr_pkg::*;

	// Mask of low counter bits that must all be one for a divided tick
	function automatic logic [6:0] rate_mask(input logic [2:0] sel);
		rate_mask = 7'h7F >> (3'h7 - sel);
		if (sel == 3'h0) begin
			rate_mask = 7'h00;
		end
	endfunction

	// Two-of-three vote on the three centre samples
	function automatic logic vote(input logic [2:0] s);
		vote = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
	endfunction

	logic [2:0] rate_divider_select;
	logic [1:0] prescaler_select_q;
	asr_byte_t ctrl_q;
	logic [1:0] pre_cnt_q;
	logic pre_tick;
	logic [6:0] rdiv_cnt_q;
	logic rt_tick;
	logic [3:0] bdiv_cnt_q;
	logic bit_tick;
	asr_byte_t stat_q;
	asr_byte_t seen_q;
	asr_byte_t set_flags;
	asr_byte_t clr_flags;
	asr_byte_t tx_holding_buffer;
	logic hold_full_q;
	logic [9:0] tx_shift_q;
	logic [3:0] tx_bit_q;
	asr_tx_state_t tx_state_q;
	logic tx_on_prev_q;
	logic tx_done_evt;
	logic tx_load;
	asr_byte_t rx_holding_buffer;
	asr_rx_state_t rx_state_q;
	logic [3:0] rx_rt_q;
	logic [3:0] rx_bit_q;
	logic [2:0] rx_samp_q;
	logic [8:0] rx_shift_q;
	logic rx_noise_q;
	logic rx_end;
	logic rx_stop;
	logic rx_noisy;
	logic [7:0] idle_cnt_q;
	logic line_busy_q;
	logic idle_evt;
	logic tx_on_bit;
	logic wr_data;
	logic rd_data;
	logic rd_stat;

	assign tx_on_bit = ctrl_q[`ASR_B_TXON];
	assign wr_data = reg_wr && (reg_addr == `ASR_A_DATA);
	assign rd_data = reg_rd && (reg_addr == `ASR_A_DATA);
	assign rd_stat = reg_rd && (reg_addr == `ASR_A_STAT);

	// Rate select register, deliberately outside the reset net
	always_ff @(posedge core_clk) begin
		if (reg_wr && reg_addr == `ASR_A_RATE) begin
			rate_divider_select <= reg_wdata[`ASR_F_RSEL];
		end
	end

	// Prescaler select and control register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prescaler_select_q <= `ASR_RST_PSEL;
			ctrl_q <= `ASR_RST_CTRL;
		end else if (reg_wr) begin
			if (reg_addr == `ASR_A_RATE) begin
				prescaler_select_q <= reg_wdata[`ASR_F_PSEL];
			end
			if (reg_addr == `ASR_A_CTRL) begin
				ctrl_q <= reg_wdata;
			end
		end
	end

	// Prescaler: divides core clock by select plus one
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pre_cnt_q <= 2'h0;
		end else if (pre_tick) begin
			pre_cnt_q <= 2'h0;
		end else begin
			pre_cnt_q <= pre_cnt_q + 2'h1;
		end
	end
	assign pre_tick = (pre_cnt_q == prescaler_select_q);

	// Binary rate divider giving the 16x sample clock
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdiv_cnt_q <= 7'h00;
		end else if (pre_tick) begin
			rdiv_cnt_q <= rdiv_cnt_q + 7'h01;
		end
	end
	assign rt_tick = pre_tick && ((rdiv_cnt_q & rate_mask(rate_divider_select)) ==
		rate_mask(rate_divider_select));

	// Divide by sixteen for the bit clock
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			bdiv_cnt_q <= 4'h0;
		end else if (rt_tick) begin
			bdiv_cnt_q <= bdiv_cnt_q + 4'h1;
		end
	end
	assign bit_tick = rt_tick && (bdiv_cnt_q == `ASR_BIT_LAST);

	// Transmit holding buffer: written only while the transmitter is on
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tx_holding_buffer <= 8'h00;
			hold_full_q <= 1'b0;
		end else if (!tx_on_bit) begin
			hold_full_q <= 1'b0;
		end else if (wr_data) begin
			tx_holding_buffer <= reg_wdata;
			hold_full_q <= 1'b1;
		end else if (tx_load) begin
			hold_full_q <= 1'b0;
		end
	end

	// Shifter loads on a bit tick when idle or ending a stop bit, enabled and a character waits
	assign tx_load = bit_tick && hold_full_q && tx_on_bit &&
		(tx_state_q == ASR_TX_IDLE || tx_bit_q == `ASR_STOP_BIT);

	// Character ends after the stop bit; queue empty or transmitter off
	assign tx_done_evt = bit_tick && tx_state_q == ASR_TX_SHIFT &&
		tx_bit_q == `ASR_STOP_BIT && !tx_load;

	// Transmit shifter: disable never cuts a frame short
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tx_state_q <= ASR_TX_IDLE;
			tx_shift_q <= 10'h3FF;
			tx_bit_q <= 4'h0;
		end else begin
			case (tx_state_q)
				ASR_TX_IDLE: begin
					if (tx_load) begin
						tx_shift_q <= {1'b1, tx_holding_buffer, 1'b0};
						tx_bit_q <= 4'h0;
						tx_state_q <= ASR_TX_SHIFT;
					end
				end
				ASR_TX_SHIFT: begin
					if (tx_load) begin
						tx_shift_q <= {1'b1, tx_holding_buffer, 1'b0};
						tx_bit_q <= 4'h0;
					end else if (tx_done_evt) begin
						tx_shift_q <= 10'h3FF;
						tx_state_q <= ASR_TX_IDLE;
					end else if (bit_tick) begin
						tx_shift_q <= {1'b1, tx_shift_q[9:1]};
						tx_bit_q <= tx_bit_q + 4'h1;
					end
				end
				default: begin
					tx_state_q <= ASR_TX_IDLE;
				end
			endcase
		end
	end

	// Pin ownership: taken on enable, released on a bit tick once idle and off
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tx_pin_oe <= 1'b0;
			tx_pin_out <= 1'b1;
			tx_on_prev_q <= 1'b0;
		end else begin
			tx_on_prev_q <= tx_on_bit;
			tx_pin_out <= tx_shift_q[0];
			if (tx_on_bit) begin
				tx_pin_oe <= 1'b1;
			end else if (bit_tick && tx_state_q == ASR_TX_IDLE) begin
				tx_pin_oe <= 1'b0;
			end
		end
	end

	// Receive sampler: start detect, three centre samples per bit
	assign rx_end = rt_tick && rx_state_q == ASR_RX_BITS &&
		rx_rt_q == `ASR_RT_LAST && rx_bit_q == `ASR_STOP_BIT;
	assign rx_stop = vote(rx_samp_q);
	assign rx_noisy = rx_noise_q || (rx_samp_q != 3'h0 && rx_samp_q != 3'h7);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_state_q <= ASR_RX_IDLE;
			rx_rt_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_samp_q <= 3'h7;
			rx_shift_q <= 9'h000;
			rx_noise_q <= 1'b0;
		end else if (rt_tick) begin
			case (rx_state_q)
				ASR_RX_IDLE: begin
					if (!rx_pin) begin
						rx_state_q <= ASR_RX_BITS;
						rx_rt_q <= 4'h1;
						rx_bit_q <= 4'h0;
						rx_noise_q <= 1'b0;
					end
				end
				ASR_RX_BITS: begin
					rx_rt_q <= rx_rt_q + 4'h1;
					if (rx_rt_q == `ASR_RT_S0) begin
						rx_samp_q[0] <= rx_pin;
					end
					if (rx_rt_q == `ASR_RT_S1) begin
						rx_samp_q[1] <= rx_pin;
					end
					if (rx_rt_q == `ASR_RT_S2) begin
						rx_samp_q[2] <= rx_pin;
					end
					if (rx_rt_q == `ASR_RT_LAST) begin
						rx_noise_q <= rx_noisy;
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == 4'h0 && vote(rx_samp_q)) begin
							rx_state_q <= ASR_RX_IDLE; // False start
						end else if (rx_bit_q == `ASR_STOP_BIT) begin
							rx_state_q <= ASR_RX_IDLE;
						end else if (rx_bit_q != 4'h0) begin
							rx_shift_q <= {vote(rx_samp_q), rx_shift_q[8:1]};
						end
					end
				end
				default: begin
					rx_state_q <= ASR_RX_IDLE;
				end
			endcase
		end
	end

	// Receive holding buffer: kept on overrun
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_holding_buffer <= 8'h00;
		end else if (rx_end && !stat_q[`ASR_B_RXF]) begin
			rx_holding_buffer <= rx_shift_q[8:1];
		end
	end

	// Idle detect: one character time of ones after the line was busy
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			idle_cnt_q <= 8'h00;
			line_busy_q <= 1'b0;
		end else if (!rx_pin) begin
			idle_cnt_q <= 8'h00;
			line_busy_q <= 1'b1;
		end else if (rt_tick && idle_cnt_q != `ASR_IDLE_RT) begin
			idle_cnt_q <= idle_cnt_q + 8'h01;
		end else if (idle_evt) begin
			line_busy_q <= 1'b0;
		end
	end
	assign idle_evt = line_busy_q && idle_cnt_q == `ASR_IDLE_RT;

	// Flag set conditions
	always_comb begin
		set_flags = 8'h00;
		set_flags[`ASR_B_TX_BUFFER_EMPTY_FLAG] = tx_load || (tx_on_bit && !tx_on_prev_q) ||
			(tx_done_evt && !tx_on_bit);
		set_flags[`ASR_B_TC] = tx_done_evt || (tx_on_bit && !tx_on_prev_q);
		set_flags[`ASR_B_RXF] = rx_end && !stat_q[`ASR_B_RXF];
		set_flags[`ASR_B_OVR] = rx_end && stat_q[`ASR_B_RXF];
		set_flags[`ASR_B_NF] = rx_end && !stat_q[`ASR_B_RXF] && rx_noisy;
		set_flags[`ASR_B_FE] = rx_end && !stat_q[`ASR_B_RXF] && !rx_stop;
		set_flags[`ASR_B_IDLE] = idle_evt;
	end

	// Clear conditions: armed by status read, fired by data access
	always_comb begin
		clr_flags = 8'h00;
		clr_flags[`ASR_B_TX_BUFFER_EMPTY_FLAG] = wr_data && seen_q[`ASR_B_TX_BUFFER_EMPTY_FLAG];
		clr_flags[`ASR_B_TC] = wr_data && seen_q[`ASR_B_TC];
		clr_flags[`ASR_B_RXF] = rd_data && seen_q[`ASR_B_RXF];
		clr_flags[`ASR_B_OVR] = rd_data && seen_q[`ASR_B_OVR];
		clr_flags[`ASR_B_NF] = rd_data && seen_q[`ASR_B_NF];
		clr_flags[`ASR_B_FE] = rd_data && seen_q[`ASR_B_FE];
		clr_flags[`ASR_B_IDLE] = rd_data && seen_q[`ASR_B_IDLE];
	end

	// Sticky flags, a set in the same cycle as a clear wins
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			stat_q <= `ASR_RST_STAT;
		end else begin
			stat_q <= (stat_q & ~clr_flags) | set_flags;
		end
	end

	// Arming snapshot of the status register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			seen_q <= 8'h00;
		end else if (rd_stat) begin
			seen_q <= stat_q;
		end else if (wr_data) begin
			seen_q <= seen_q & ~`ASR_TX_FLAGS;
		end else if (rd_data) begin
			seen_q <= seen_q & `ASR_TX_FLAGS;
		end
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`ASR_A_RATE: reg_rdata <= {2'h0, prescaler_select_q, 1'b0, rate_divider_select};
				`ASR_A_CTRL: reg_rdata <= ctrl_q;
				`ASR_A_STAT: reg_rdata <= stat_q;
				`ASR_A_DATA: reg_rdata <= rx_holding_buffer;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// One request line for all enabled sources; noise and framing excluded
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= (stat_q[`ASR_B_TX_BUFFER_EMPTY_FLAG] && ctrl_q[`ASR_B_TEIE]) ||
				(stat_q[`ASR_B_TC] && ctrl_q[`ASR_B_TX_DONE_IRQ_ON]) ||
				((stat_q[`ASR_B_RXF] || stat_q[`ASR_B_OVR]) && ctrl_q[`ASR_B_RFIE]) ||
				(stat_q[`ASR_B_IDLE] && ctrl_q[`ASR_B_IDIE]);
		end
	end
endmodule

/* File: asr_properties.sv */
// Port-level checker for the serial block
`timescale 1ns/100ps
`include "asr_consts.svh"
module asr_chk (
	input wire logic core_clk,
	input wire logic resetn,
	input wire asr_pkg::asr_addr_t reg_addr,
	input wire asr_pkg::asr_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire asr_pkg::asr_byte_t reg_rdata,
	input wire logic rx_pin,
	input wire logic tx_pin_out,
	input wire logic tx_pin_oe,
	input wire logic irq_req
);
	import asr_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	asr_byte_t ctrl_q;
	logic [5:0] rate_q;
	logic srd_q;
	logic [7:1] seen_q;
	int low_q;
	int blen;
	// Clocks per serial bit for the last rate written
	assign blen = (16 * (rate_q[5:4] + 1)) << rate_q[2:0];
	// Rate shadow, all kept over reset; the real rate select is kept, the real prescaler select resets
	always_ff @(posedge core_clk) begin
		if (reg_wr && reg_addr == `ASR_A_RATE) rate_q <= reg_wdata[5:0];
	end
	// Control shadow and status read marker
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= 8'h00;
			srd_q <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `ASR_A_CTRL) ctrl_q <= reg_wdata;
			srd_q <= reg_rd && reg_addr == `ASR_A_STAT;
		end
	end
	// Flags seen set and not yet followed by a data access
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) seen_q <= 7'h00;
		else if (reg_wr && reg_addr == `ASR_A_DATA) seen_q[7:6] <= 2'h0;
		else if (reg_rd && reg_addr == `ASR_A_DATA) seen_q[5:1] <= 5'h00;
		else if (srd_q) seen_q <= seen_q | reg_rdata[7:1];
	end
	// Length of the current low run on the transmit pin
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) low_q <= 0;
		else if (tx_pin_out) low_q <= 0;
		else low_q <= low_q + 1;
	end
	bit_length_a: assert property ($rose(tx_pin_out) && tx_pin_oe |-> low_q % blen == 0)
		else $error("low run is not whole bits");
	char_finish_a: assert property (tx_pin_oe && !tx_pin_out |=> tx_pin_oe)
		else $error("pin released inside a character");
	pin_idle_a: assert property (!tx_pin_oe |-> tx_pin_out)
		else $error("released pin not idle high");
	tx_enable_a: assert property (reg_wr && reg_addr == `ASR_A_CTRL && reg_wdata[3] |-> ##[1:2] tx_pin_oe)
		else $error("enable did not take the pin");
	flag_hold_a: assert property (srd_q |-> (reg_rdata[7:1] & seen_q) == seen_q)
		else $error("flag cleared without sequence");
	tx_irq_a: assert property (srd_q && |(reg_rdata[7:6] & ctrl_q[7:6]) |-> ##[0:1] irq_req)
		else $error("tx interrupt missing");
	rx_irq_a: assert property (srd_q && |({reg_rdata[5:3]} & {ctrl_q[5:4], ctrl_q[5]}) |-> ##[0:1] irq_req)
		else $error("rx interrupt missing");
	irq_mask_a: assert property (ctrl_q[7:4] == 4'h0 && $past(ctrl_q[7:4]) == 4'h0 |-> !irq_req)
		else $error("interrupt with all sources masked");
endmodule
bind asr_serial asr_chk asr_chk_i (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .rx_pin, .tx_pin_out, .tx_pin_oe, .irq_req);

/* File: asr_remote.sv */
// Remote serial station: sends frames to the block and collects its frames
`timescale 1ns/100ps
module asr_remote (
	input wire logic core_clk,
	input wire logic line_in,
	output logic line_out
);
	import asr_pkg::*;
	int bit_len = 16;
	asr_byte_t got_q[$];
	asr_byte_t sh;
	initial line_out = 1'b1;
	// Collect frames centre-sampled, keep those with a good stop bit
	always begin
		@(negedge line_in);
		repeat (bit_len / 2) @(posedge core_clk);
		if (!line_in) begin
			for (int i = 0; i < 8; i++) begin
				repeat (bit_len) @(posedge core_clk);
				sh[i] = line_in;
			end
			repeat (bit_len) @(posedge core_clk);
			if (line_in) got_q.push_back(sh);
		end
	end
	// Drive one frame, LSB first; bad stop level and a one-clock glitch on request
	task automatic send(input asr_byte_t b, input logic stop, input logic glitch);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int k = 0; k < 10; k++) begin
			line_out <= f[k];
			repeat (bit_len / 2) @(posedge core_clk);
			if (glitch && k == 1) begin
				line_out <= ~f[k];
				@(posedge core_clk);
				line_out <= f[k];
			end else @(posedge core_clk);
			repeat (bit_len / 2 - 1) @(posedge core_clk);
		end
		line_out <= 1'b1;
	endtask
endmodule

/* File: tb_top.sv */
// Testbench for the serial block
`timescale 1ns/100ps
`include "asr_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
	import asr_pkg::*;
	logic core_clk, resetn, reg_wr, reg_rd, tx_pin_out, tx_pin_oe, irq_req, rx_pin;
	asr_addr_t reg_addr;
	asr_byte_t reg_wdata, reg_rdata, d, x;
	asr_byte_t q[$];
	wire tx_line;
	int errors, cmp_count;
	logic [31:0] seed = 32'h00002BC3;
	// Transmit wire: pulled high when the block lets go
	assign tx_line = tx_pin_oe ? tx_pin_out : 1'b1;
	asr_serial asr_serial_i (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_pin, .tx_pin_out, .tx_pin_oe, .irq_req);
	asr_remote asr_remote_i (.core_clk, .line_in(tx_line), .line_out(rx_pin));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Receive flags expected for each row of the frame table
	function asr_byte_t exp_stat(input int i);
		return 8'h30 | (i == 1 ? 8'h08 : 8'h00) | (i == 2 ? 8'h02 : 8'h00) | (i == 3 ? 8'h04 : 8'h00);
	endfunction
	task wr(input asr_addr_t a, input asr_byte_t v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task rd(input asr_addr_t a, output asr_byte_t v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge core_clk);
	endtask
	// Read status until the given flag shows, with a bound
	task poll(input int b);
		d = 8'h00;
		for (int n = 0; n < 3000 && d[b] !== 1'b1; n++) rd(`ASR_A_STAT, d);
		if (d[b] !== 1'b1) errors++;
	endtask
	task put(input asr_byte_t v);
		poll(7);
		wr(`ASR_A_DATA, v);
	endtask
	task wait_rx(input int n);
		for (int k = 0; k < 6000 && asr_remote_i.got_q.size() < n; k++) @(posedge core_clk);
		if (asr_remote_i.got_q.size() < n) errors++;
	endtask
	task chk_irq(input logic v);
		@(posedge core_clk);
		`CHK(irq_req, v)
	endtask
	task stop_test();
		$display("errors %0d, compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		errors++;
		stop_test();
	end
	initial begin
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		resetn = 1'b0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		`CHK({tx_pin_oe, tx_pin_out, irq_req}, 3'b010)
		wr(`ASR_A_STAT, 8'hFF);
		rd(`ASR_A_STAT, d);
		`CHK(d, 8'h00)
		wr(`ASR_A_RATE, 8'h00);
		wr(`ASR_A_CTRL, 8'h88);
		rd(`ASR_A_STAT, d);
		`CHK(d[7:6], 2'h3)
		chk_irq(1'b1);
		// Random characters queued as soon as the buffer frees
		for (int i = 0; i < 4; i++) begin
			x = 8'(xs());
			q.push_back(x);
			put(x);
		end
		wait_rx(4);
		foreach (q[i]) `CHK(asr_remote_i.got_q[i], q[i])
		poll(6);
		`CHK(d[6], 1'b1)
		wr(`ASR_A_CTRL, 8'h48);
		chk_irq(1'b1);
		wr(`ASR_A_CTRL, 8'h08);
		chk_irq(1'b0);
		// Switch off while one character shifts and one waits
		asr_remote_i.got_q.delete();
		x = 8'(xs());
		put(x);
		put(~x);
		wr(`ASR_A_CTRL, 8'h00);
		wait_rx(1);
		repeat (200) @(posedge core_clk);
		`CHK(asr_remote_i.got_q.size(), 1)
		`CHK(asr_remote_i.got_q[0], x)
		`CHK(tx_pin_oe, 1'b0)
		rd(`ASR_A_STAT, d);
		`CHK(d[7:6], 2'h3)
		// Received frames: plain, overrun, bad stop, noisy
		wr(`ASR_A_CTRL, 8'h30);
		for (int i = 0; i < 4; i++) begin
			x = 8'(xs());
			asr_remote_i.send(x, i != 2, i == 3);
			if (i == 1) asr_remote_i.send(~x, 1'b1, 1'b0);
			repeat (180) @(posedge core_clk);
			rd(`ASR_A_STAT, d);
			`CHK(d & 8'h3E, exp_stat(i))
			rd(`ASR_A_DATA, d);
			`CHK(d, x)
			repeat (180) @(posedge core_clk);
			rd(`ASR_A_STAT, d);
			`CHK(d & 8'h3E, 8'h00)
		end
		// Random divider settings, one character each way, changed only when idle
		for (int i = 0; i < 2; i++) begin
			x = 8'(xs());
			d = {2'h0, 2'(xs()), 1'b0, 3'(xs() % 3)};
			asr_remote_i.bit_len = (16 * (d[5:4] + 1)) << d[2:0];
			wr(`ASR_A_RATE, d);
			wr(`ASR_A_CTRL, 8'h08);
			asr_remote_i.got_q.delete();
			put(x);
			wait_rx(1);
			`CHK(asr_remote_i.got_q[0], x)
			asr_remote_i.send(~x, 1'b1, 1'b0);
			// Status read first, so the data read clears the full flag for the next pass
			rd(`ASR_A_STAT, d);
			`CHK(d[5], 1'b1)
			rd(`ASR_A_DATA, d);
			`CHK(d, ~x)
			// Switched off while idle: pin handed back at the next bit tick
			wr(`ASR_A_CTRL, 8'h00);
			repeat (asr_remote_i.bit_len + 2) @(posedge core_clk);
			`CHK(tx_pin_oe, 1'b0)
			wr(`ASR_A_CTRL, 8'h08);
		end
		// Reset in mid character: pin freed at once, divider kept
		wr(`ASR_A_RATE, 8'h01);
		asr_remote_i.bit_len = 32;
		put(x);
		repeat (80) @(posedge core_clk);
		resetn <= 1'b0;
		@(posedge core_clk);
		`CHK({tx_pin_oe, tx_pin_out}, 2'b01)
		resetn <= 1'b1;
		@(posedge core_clk);
		rd(`ASR_A_RATE, d);
		`CHK(d[5:0], 6'h01)
		stop_test();
	end
endmodule
